// [logic/acsr_map.vh]
// register offsets, field positions and reset values of the status/ident register pair
`ifndef ACSR_MAP_VH
`define ACSR_MAP_VH
`define ACSR_IDX_IDENT 4'h0
`define ACSR_IDX_STATUS 4'h1
`define ACSR_IDX_IRQ_STAT 4'h2
`define ACSR_IDX_IRQ_MASK 4'h3
`define ACSR_IDX_CTRL 4'h4
`define ACSR_ADR_IDENT 8'h00
`define ACSR_ADR_STATUS 8'h04
`define ACSR_ADR_IRQ_STAT 8'h08
`define ACSR_ADR_IRQ_MASK 8'h0C
`define ACSR_ADR_CTRL 8'h10
`define ACSR_BIT_LOCK 15
`define ACSR_BIT_RESYNC 14
`define ACSR_BIT_MAPFLT 13
`define ACSR_BIT_CRCERR 12
`define ACSR_BIT_CRCTYPE 11
`define ACSR_BIT_RSTFLG 10
`define ACSR_STATUS_RST 16'h0500
`define ACSR_WSIZE_RST 2'h1
// arbitrary identification nibble, not tied to any real part
`define ACSR_ID_TOP 4'h6
`define ACSR_ID_CHANS 4'h8
`define ACSR_ID_LOW 8'h5A
`define ACSR_ZERO16 16'h0000
`define ACSR_ZERO32 32'h0000_0000
`endif

// [logic/acsr_status_ident_regs.v]
// status and identification registers with a wishbone slave and an interrupt
// Contract
// - bit 15 shows interface lock, 1 locked, 0 unlocked at reset.
// - bit 14 set on each converter resync, 0 after reset.
// - bit 13 set when register-map crc changes, 0 while unchanged; here it stays 1 until a one is written to bit 13 of irq status.
// - bit 12 set on input crc error, reset value 0.
// - bit 11 shows crc polynomial, 0 ccitt default, 1 ansi.
// - bit 10 reads 1 after reset until cleared.
// - bits 9:8 word size code, 01 after reset; here they mirror i_sample_word_size directly, with no reset value of their own.
// - bits 7:0 new-sample flag per channel, bit n for channel n.
// - ident low byte may hold any value; host must not rely on it.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "acsr_map.vh"
module acsr_status_ident_regs (
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  output wire o_wb_err,
  // core status inputs (same clock domain)
  input wire i_locked,
  input wire i_resync_pulse,
  input wire [15:0] i_map_crc,
  input wire i_crc_err_pulse,
  input wire i_crc_ansi,
  input wire [1:0] i_sample_word_size,
  input wire [7:0] i_new_sample_set,
  input wire [7:0] i_new_sample_clr,
  // interrupt
  output wire o_irq
);

  reg rst_s1_r;
  reg rstn_r;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_r <= 1'b0;
      rstn_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rstn_r <= rst_s1_r;
    end
  end

  reg resync_r;
  reg mapflt_r;
  reg crcerr_r;
  reg rstflg_r;
  reg [7:0] new_sample_r;
  reg [15:0] crc_prev_r;
  reg crc_seen_r;
  reg [15:0] irq_stat_r;
  reg [15:0] irq_mask_r;
  reg [15:0] ctrl_r;
  wire [15:0] status_w;
  wire [15:0] ident_w;
  wire [15:0] events_w;
  wire crc_changed_w;
  wire req_w;
  wire wr_w;
  wire wr_stat_w;
  wire wr_mask_w;
  wire wr_ctrl_w;
  wire hit_w;

  assign req_w = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_w = req_w & i_wb_we & i_wb_sel[0] & i_wb_sel[1];
  // ident and status writes fall through decode untouched
  assign wr_stat_w = wr_w && (i_wb_adr == `ACSR_ADR_IRQ_STAT);
  assign wr_mask_w = wr_w && (i_wb_adr == `ACSR_ADR_IRQ_MASK);
  assign wr_ctrl_w = wr_w && (i_wb_adr == `ACSR_ADR_CTRL);
  assign hit_w = (i_wb_adr == `ACSR_ADR_IDENT) || (i_wb_adr == `ACSR_ADR_STATUS) ||
    (i_wb_adr == `ACSR_ADR_IRQ_STAT) || (i_wb_adr == `ACSR_ADR_IRQ_MASK) ||
    (i_wb_adr == `ACSR_ADR_CTRL);
  assign o_wb_err = 1'b0;

  // first sample after reset is a baseline, not a change
  assign crc_changed_w = crc_seen_r && (i_map_crc != crc_prev_r);
  // ctrl bit 0 write of one clears the reset flag (software acknowledge)
  wire rst_ack_w = wr_ctrl_w & i_wb_dat[0];

  always @(posedge i_clk or negedge rstn_r) begin
    if (!rstn_r) begin
      resync_r <= 1'b0;
      mapflt_r <= 1'b0;
      crcerr_r <= 1'b0;
      rstflg_r <= 1'b1;
      new_sample_r <= 8'h00;
      crc_prev_r <= `ACSR_ZERO16;
      crc_seen_r <= 1'b0;
      ctrl_r <= `ACSR_ZERO16;
    end else begin
      crc_prev_r <= i_map_crc;
      crc_seen_r <= 1'b1;
      // resync, map-fault and crc-error flags are held by hardware; cleared through the irq status word
      if (i_resync_pulse)
        resync_r <= 1'b1;
      else if (wr_stat_w && i_wb_dat[`ACSR_BIT_RESYNC])
        resync_r <= 1'b0;
      if (crc_changed_w)
        mapflt_r <= 1'b1;
      else if (wr_stat_w && i_wb_dat[`ACSR_BIT_MAPFLT])
        mapflt_r <= 1'b0;
      if (i_crc_err_pulse)
        crcerr_r <= 1'b1;
      else if (wr_stat_w && i_wb_dat[`ACSR_BIT_CRCERR])
        crcerr_r <= 1'b0;
      if (rst_ack_w)
        rstflg_r <= 1'b0;
      // set wins over clear per channel
      new_sample_r <= i_new_sample_set | (new_sample_r & ~i_new_sample_clr);
      if (wr_ctrl_w)
        ctrl_r <= `ACSR_ZERO16;
    end
  end

  assign status_w = {i_locked, resync_r, mapflt_r, crcerr_r, i_crc_ansi, rstflg_r,
    i_sample_word_size, new_sample_r};
  // low byte arbitrary; host must mask it
  assign ident_w = {`ACSR_ID_TOP, `ACSR_ID_CHANS, `ACSR_ID_LOW};

  assign events_w = {1'b0, i_resync_pulse, crc_changed_w, i_crc_err_pulse, 4'h0, i_new_sample_set};

  always @(posedge i_clk or negedge rstn_r) begin
    if (!rstn_r) begin
      irq_stat_r <= `ACSR_ZERO16;
      irq_mask_r <= `ACSR_ZERO16;
    end else begin
      // set wins over write-one-clear
      irq_stat_r <= events_w | (irq_stat_r & ~(wr_stat_w ? i_wb_dat[15:0] : `ACSR_ZERO16));
      if (wr_mask_w)
        irq_mask_r <= i_wb_dat[15:0];
    end
  end
  assign o_irq = |(irq_stat_r & irq_mask_r);

  // one wait state: ack one cycle after the request is seen
  always @(posedge i_clk or negedge rstn_r) begin
    if (!rstn_r) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `ACSR_ZERO32;
    end else begin
      o_wb_ack <= req_w;
      if (req_w && !i_wb_we) begin
        if (i_wb_adr == `ACSR_ADR_IDENT)
          o_wb_dat <= {`ACSR_ZERO16, ident_w};
        else if (i_wb_adr == `ACSR_ADR_STATUS)
          o_wb_dat <= {`ACSR_ZERO16, status_w};
        else if (i_wb_adr == `ACSR_ADR_IRQ_STAT)
          o_wb_dat <= {`ACSR_ZERO16, irq_stat_r};
        else if (i_wb_adr == `ACSR_ADR_IRQ_MASK)
          o_wb_dat <= {`ACSR_ZERO16, irq_mask_r};
        else if (hit_w)
          o_wb_dat <= {`ACSR_ZERO16, ctrl_r};
        else
          o_wb_dat <= `ACSR_ZERO32;
      end
    end
  end

endmodule
`default_nettype wire

// [verification/acsr_chk_sva.sv]
// assertions on the status/ident register pair
`timescale 1ns/100ps
`default_nettype none
`include "acsr_map.vh"
module acsr_chk (
  input wire logic i_clk, i_rstn, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, i_locked, i_crc_ansi,
  input wire logic [7:0] i_wb_adr, i_new_sample_set,
  input wire logic [1:0] i_sample_word_size,
  input wire logic [31:0] o_wb_dat
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire st = o_wb_ack && !i_wb_we && i_wb_adr == `ACSR_ADR_STATUS;
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  chk_ack_delay: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  chk_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000) else $error("upper bits");
  chk_ident_top: assert property (o_wb_ack && !i_wb_we && !i_wb_adr
    |-> o_wb_dat[15:8] == {`ACSR_ID_TOP, `ACSR_ID_CHANS}) else $error("ident");
  chk_lock_bit: assert property (st |-> o_wb_dat[15] == $past(i_locked)) else $error("lock");
  chk_crc_kind: assert property (st |-> o_wb_dat[11] == $past(i_crc_ansi)) else $error("crc kind");
  chk_word_size: assert property (st |-> o_wb_dat[9:8] == $past(i_sample_word_size)) else $error("size");
  chk_new_sample: assert property (st |-> (o_wb_dat[7:0] & $past(i_new_sample_set, 2))
    == $past(i_new_sample_set, 2)) else $error("new sample");
endmodule
`default_nettype wire

// [verification/acsr_host.sv]
// wishbone host model issuing classic single cycles
`timescale 1ns/100ps
`default_nettype none
module acsr_host (
  input wire logic i_clk, i_ack,
  input wire logic [31:0] i_dat,
  output var logic o_cyc, o_we,
  output var logic [7:0] o_adr,
  output var logic [31:0] o_dat
);
  logic hung = 1'b0;
  initial {o_cyc, o_we, o_adr, o_dat} = '0;
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge i_clk);
    {o_cyc, o_we, o_adr, o_dat} <= {1'b1, w, a, d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!i_ack && n < 20);
    q = i_dat;
    hung = !i_ack;
    o_cyc <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/acsr_status_ident_regs_tb.sv]
// testbench for the status/ident register pair
`timescale 1ns/100ps
`default_nettype none
`include "acsr_map.vh"
module acsr_status_ident_regs_tb;
  logic i_clk = 0, i_rstn = 0, c, we, i_locked = 0, rs = 0, ce = 0, an = 0, ack, irq;
  logic [1:0] ws = 2'h1;
  logic [7:0] adr, ns = 8'h00, nc = 8'h00;
  logic [15:0] crc = 16'h0000;
  logic [31:0] wd, rq, q;
  int bad_count = 0, comparisons = 0;
  initial forever #2.5 i_clk = ~i_clk;
  acsr_host u_host (.i_clk, .i_ack(ack), .i_dat(rq), .o_cyc(c), .o_we(we), .o_adr(adr), .o_dat(wd));
  acsr_status_ident_regs u_dut (.i_clk, .i_rstn, .i_wb_cyc(c), .i_wb_stb(c), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hF), .i_wb_dat(wd), .o_wb_dat(rq), .o_wb_ack(ack), .o_wb_err(), .i_locked, .i_resync_pulse(rs),
    .i_map_crc(crc), .i_crc_err_pulse(ce), .i_crc_ansi(an), .i_sample_word_size(ws), .i_new_sample_set(ns),
    .i_new_sample_clr(nc), .o_irq(irq));
  task cmp(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t %h %h", $time, g, e);
    end
  endtask
  task complete_run;
    $display("compares %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    u_host.xfer(w, a, {16'h0000, d}, q);
    if (u_host.hung) begin
      bad_count++;
      complete_run;
    end
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e, m);
    acc(0, a, 0);
    cmp(q & {16'hFFFF, m}, {16'h0000, e});
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rstn <= 1;
    repeat (3) @(posedge i_clk);
    rd(8'h04, 16'h0500, 16'hFFFF);
    rd(8'h00, {`ACSR_ID_TOP, `ACSR_ID_CHANS, 8'h00}, 16'hFF00);
    acc(1, 8'h00, 16'hFFFF);
    acc(1, 8'h04, 16'hFFFF);
    rd(8'h04, 16'h0500, 16'hFFFF);
    $display("reset test done");
    i_locked <= 1;
    an <= 1;
    for (int i = 0; i < 4; i++) begin
      ws <= i[1:0];
      rd(8'h04, {8'h8C | i[7:0], 8'h00}, 16'hFFFF);
    end
    $display("field test done");
    {ns, rs, ce, crc} <= {8'h81, 2'h3, 16'h1234};
    @(posedge i_clk);
    {ns, rs, ce} <= 0;
    rd(8'h04, 16'hFF81, 16'hFFFF);
    acc(1, 8'h0C, 16'h7000);
    cmp({31'h0000_0000, irq}, 1);
    acc(1, 8'h08, 16'h7000);
    cmp({31'h0000_0000, irq}, 0);
    nc <= 8'h01;
    @(posedge i_clk);
    nc <= 0;
    acc(1, 8'h10, 16'h0001);
    rd(8'h04, 16'h8B80, 16'hFFFF);
    rd(8'h14, 16'h0000, 16'hFFFF);
    $display("event test done");
    complete_run;
  end
endmodule
bind acsr_status_ident_regs acsr_chk u_chk (.i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .o_wb_ack,
  .i_locked, .i_crc_ansi, .i_wb_adr, .i_new_sample_set, .i_sample_word_size, .o_wb_dat);
`default_nettype wire
